// File: sdsm_drive.sv
// Drive profile core: cycle sync, state machine, state word and operation modes
// Operation
// - Master and drive share a reference time; synchronous mode follows its sync event.
// - Sync mode input selects free-running or distributed-clock synchronous operation.
// - Free-running mode ticks from its own counter, ignoring network timing unless correction is enabled.
// - Free-running correction realigns the cycle counter on sync manager events.
// - Distributed-clock mode ticks the control cycle on each sync event.
// - A servo alarm queues an emergency message; dropped if link is down.
// - Message bytes: code, error register, zero, alarm code, zero pair.
// - Eight drive states, not ready after reset.
// - Alarm enters fault reaction, runs its sequence, then holds fault.
// - Command bits 3..0 decode shutdown, switch on, enable and disable operation.
// - Bit 1 low disables voltage; quick stop; bit 7 rise resets fault.
// - State word bits 6,5,3,2,1,0 encode the state; bit 4 independent.
// - Other state word bits carry voltage, warning, remote, target, limit, mode, abs, busy; bit 8 stays zero.
// - Seven operation modes accepted through the mode select object.
// - Read-only mode display and read-only supported mode set.
// - Feed-forward, filter and observer enabled per mode class.
// - Homing applies velocity feed-forward and filter per current operating condition.
`timescale 1ns/10ps
module sdsm_drive #(
	parameter int FREE_CYCLES = sdsm_pkg::FREE_CYCLE_CYCLES,
	parameter int REACT_CYCLES = sdsm_pkg::FAULT_REACT_CYCLES
) (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sync_mode_i,
	input  wire logic        sm_corr_en_i,
	input  wire logic        sync_event_i,
	input  wire logic        sm_event_i,
	input  wire logic [15:0] obj_index_i,
	input  wire logic        obj_wr_i,
	input  wire logic        obj_rd_i,
	input  wire logic [31:0] obj_wdata_i,
	input  wire logic        alarm_i,
	input  wire logic [15:0] alarm_code_i,
	input  wire logic        link_up_i,
	input  wire logic        emcy_ack_i,
	input  wire logic        voltage_on_i,
	input  wire logic        warning_i,
	input  wire logic        target_reached_i,
	input  wire logic        limit_active_i,
	input  wire logic [1:0]  mode_spec_i,
	input  wire logic        abs_valid_i,
	input  wire logic        busy_i,
	input  wire logic        homing_pos_ctrl_i,
	output logic             cycle_tick_o,
	output logic [2:0]       drive_state_o,
	output logic [31:0]      obj_rdata_o,
	output logic             obj_ack_o,
	output logic             obj_err_o,
	output logic             emcy_valid_o,
	output logic [63:0]      emcy_data_o,
	output logic             vel_ff_en_o,
	output logic             pos_filter_en_o,
	output logic             torque_ff_en_o,
	output logic             observer_en_o,
	output logic             common_en_o
);
	if (FREE_CYCLES < 2 || FREE_CYCLES > 65535 || REACT_CYCLES < 1 || REACT_CYCLES > 65535) begin : g_chk
		$error("sdsm_drive: cycle counts out of range");
	end

	localparam logic [15:0] CYC_LAST   = 16'(FREE_CYCLES - 1);
	localparam logic [15:0] REACT_LAST = 16'(REACT_CYCLES - 1);

	typedef struct packed {
		logic                 sync_meta;
		logic                 sync_sync;
		logic                 sync_prev;
		logic                 sm_meta;
		logic                 sync_manager_cycle_correction;
		logic                 sm_prev;
		logic [15:0]          cyc_cnt;
		logic                 tick;
		logic [15:0]          cmd;
		logic                 cw7_prev;
		sdsm_pkg::sdsm_state_e state;
		logic [15:0]          react_cnt;
		logic [15:0]          sw;
		logic [7:0]           mode_sel;
		logic [7:0]           mode_disp;
		logic                 alarm_prev;
		logic                 alarm_evt;
		logic [15:0]          alarm_code;
		logic [31:0]          rdata;
		logic                 ack;
		logic                 err;
		logic                 vel_ff;
		logic                 pos_filt;
		logic                 trq_ff;
		logic                 dob;
		logic                 common;
	} sdsm_core_s;

	sdsm_core_s  s_reg;
	sdsm_core_s  s_next;
	sdsm_emcy_if emcy ();

	function automatic logic [5:0] state_code(input sdsm_pkg::sdsm_state_e st);
		unique case (st)
			sdsm_pkg::ST_NOT_READY:   state_code = sdsm_pkg::CODE_NOT_READY;
			sdsm_pkg::ST_SW_DISABLED: state_code = sdsm_pkg::CODE_SW_DISABLED;
			sdsm_pkg::ST_READY:       state_code = sdsm_pkg::CODE_READY;
			sdsm_pkg::ST_SWITCHED_ON: state_code = sdsm_pkg::CODE_SWITCHED_ON;
			sdsm_pkg::ST_OP_ENABLED:  state_code = sdsm_pkg::CODE_OP_ENABLED;
			sdsm_pkg::ST_QUICK_STOP:  state_code = sdsm_pkg::CODE_QUICK_STOP;
			sdsm_pkg::ST_FAULT_REACT: state_code = sdsm_pkg::CODE_FAULT_REACT;
			sdsm_pkg::ST_FAULT:       state_code = sdsm_pkg::CODE_FAULT;
		endcase
	endfunction : state_code

	function automatic logic mode_supported(input logic [7:0] m);
		mode_supported = (m == sdsm_pkg::profile_position_mode) || (m == sdsm_pkg::homing_mode)
			|| (m == sdsm_pkg::profile_velocity_mode) || (m == sdsm_pkg::profile_torque_mode)
			|| (m == sdsm_pkg::cyclic_position_mode) || (m == sdsm_pkg::cyclic_velocity_mode)
			|| (m == sdsm_pkg::cyclic_torque_mode);
	endfunction : mode_supported

	// Command decode shared by the state machine and the checks
	logic cmd_shutdown;
	logic cmd_switch_on;
	logic cmd_enable;
	logic cmd_dis_volt;
	logic cmd_qstop;
	logic fault_reset;
	logic sync_edge;
	logic sm_edge;
	logic alarm_free;

	assign cmd_shutdown  = s_reg.cmd[2:0] == 3'b110;
	assign cmd_switch_on = s_reg.cmd[3:0] == 4'b0111;
	assign cmd_enable    = s_reg.cmd[3:0] == 4'b1111;
	assign cmd_dis_volt  = !s_reg.cmd[1];
	assign cmd_qstop     = s_reg.cmd[2:1] == 2'b01;
	// Held level re-arms only after bit 7 drops
	assign fault_reset   = s_reg.cmd[sdsm_pkg::CW_FAULT_RESET_BIT] && !s_reg.cw7_prev;
	assign sync_edge     = s_reg.sync_sync && !s_reg.sync_prev;
	assign sm_edge       = s_reg.sync_manager_cycle_correction && !s_reg.sm_prev;
	assign alarm_free    = s_reg.state != sdsm_pkg::ST_FAULT_REACT && s_reg.state != sdsm_pkg::ST_FAULT
		&& s_reg.state != sdsm_pkg::ST_NOT_READY;

	always_comb begin
		s_next = s_reg;
		s_next.sync_meta = sync_event_i;
		s_next.sync_sync = s_reg.sync_meta;
		s_next.sync_prev = s_reg.sync_sync;
		s_next.sm_meta   = sm_event_i;
		s_next.sync_manager_cycle_correction   = s_reg.sm_meta;
		s_next.sm_prev   = s_reg.sync_manager_cycle_correction;

		// Application cycle
		s_next.tick = 1'b0;
		if (sync_mode_i == sdsm_pkg::SYNC_DC) begin
			s_next.cyc_cnt = '0;
			s_next.tick    = sync_edge;
		end else if (sm_corr_en_i && sm_edge) begin
			// Realign instead of ticking; each sync manager edge clears any drift so far
			s_next.cyc_cnt = '0;
		end else if (s_reg.cyc_cnt == CYC_LAST) begin
			s_next.cyc_cnt = '0;
			s_next.tick    = 1'b1;
		end else begin
			s_next.cyc_cnt = s_reg.cyc_cnt + 16'h0001;
		end

		// Object access
		s_next.ack = obj_rd_i || obj_wr_i;
		s_next.err = 1'b0;
		if (obj_wr_i) begin
			unique case (obj_index_i)
				sdsm_pkg::IDX_CMD_WORD:    s_next.cmd = obj_wdata_i[15:0];
				sdsm_pkg::IDX_MODE_SELECT: s_next.mode_sel = obj_wdata_i[7:0];
				default:                   s_next.err = 1'b1;
			endcase
		end else if (obj_rd_i) begin
			unique case (obj_index_i)
				sdsm_pkg::IDX_CMD_WORD:     s_next.rdata = {16'h0000, s_reg.cmd};
				sdsm_pkg::IDX_STATE_WORD:   s_next.rdata = {16'h0000, s_reg.sw};
				sdsm_pkg::IDX_MODE_SELECT:  s_next.rdata = {24'h000000, s_reg.mode_sel};
				sdsm_pkg::IDX_MODE_DISPLAY: s_next.rdata = {24'h000000, s_reg.mode_disp};
				sdsm_pkg::IDX_MODE_SET:     s_next.rdata = sdsm_pkg::SUPPORTED_MODES;
				default: begin
					s_next.rdata = 32'h0000_0000;
					s_next.err   = 1'b1;
				end
			endcase
		end

		// Unsupported selections keep the previous display
		if (mode_supported(s_reg.mode_sel)) begin
			s_next.mode_disp = s_reg.mode_sel;
		end

		// Alarm event toward the formatter
		s_next.alarm_prev = alarm_i;
		s_next.alarm_evt  = alarm_i && !s_reg.alarm_prev;
		s_next.alarm_code = alarm_code_i;

		// State machine; unmatched commands fall through unchanged
		s_next.cw7_prev = s_reg.cmd[sdsm_pkg::CW_FAULT_RESET_BIT];
		unique case (s_reg.state)
			sdsm_pkg::ST_NOT_READY: s_next.state = sdsm_pkg::ST_SW_DISABLED;
			sdsm_pkg::ST_SW_DISABLED: begin
				if (cmd_shutdown) s_next.state = sdsm_pkg::ST_READY;
			end
			sdsm_pkg::ST_READY: begin
				if (cmd_dis_volt || cmd_qstop) s_next.state = sdsm_pkg::ST_SW_DISABLED;
				else if (cmd_switch_on) s_next.state = sdsm_pkg::ST_SWITCHED_ON;
				else if (cmd_enable) s_next.state = sdsm_pkg::ST_OP_ENABLED;
			end
			sdsm_pkg::ST_SWITCHED_ON: begin
				if (cmd_dis_volt || cmd_qstop) s_next.state = sdsm_pkg::ST_SW_DISABLED;
				else if (cmd_shutdown) s_next.state = sdsm_pkg::ST_READY;
				else if (cmd_enable) s_next.state = sdsm_pkg::ST_OP_ENABLED;
			end
			sdsm_pkg::ST_OP_ENABLED: begin
				if (cmd_dis_volt) s_next.state = sdsm_pkg::ST_SW_DISABLED;
				else if (cmd_qstop) s_next.state = sdsm_pkg::ST_QUICK_STOP;
				else if (cmd_shutdown) s_next.state = sdsm_pkg::ST_READY;
				else if (cmd_switch_on) s_next.state = sdsm_pkg::ST_SWITCHED_ON;
			end
			sdsm_pkg::ST_QUICK_STOP: begin
				if (cmd_dis_volt) s_next.state = sdsm_pkg::ST_SW_DISABLED;
				else if (cmd_enable) s_next.state = sdsm_pkg::ST_OP_ENABLED;
			end
			sdsm_pkg::ST_FAULT_REACT: begin
				if (s_reg.react_cnt == REACT_LAST) begin
					s_next.state     = sdsm_pkg::ST_FAULT;
					s_next.react_cnt = '0;
				end else begin
					s_next.react_cnt = s_reg.react_cnt + 16'h0001;
				end
			end
			sdsm_pkg::ST_FAULT: begin
				// Reset is refused while the alarm persists
				if (fault_reset && !alarm_i) s_next.state = sdsm_pkg::ST_SW_DISABLED;
			end
		endcase
		if (alarm_i && alarm_free) begin
			s_next.state     = sdsm_pkg::ST_FAULT_REACT;
			s_next.react_cnt = '0;
		end

		// State word
		s_next.sw = '0;
		{s_next.sw[6], s_next.sw[5], s_next.sw[3:0]} = state_code(s_reg.state);
		s_next.sw[sdsm_pkg::SW_VOLTAGE_BIT]                   = voltage_on_i;
		s_next.sw[sdsm_pkg::SW_WARNING_BIT]                   = warning_i;
		s_next.sw[sdsm_pkg::SW_REMOTE_BIT]                    = link_up_i;
		s_next.sw[sdsm_pkg::SW_TARGET_BIT]                    = target_reached_i;
		s_next.sw[sdsm_pkg::SW_LIMIT_BIT]                     = limit_active_i;
		s_next.sw[sdsm_pkg::SW_MODE_LO_BIT +: 2]              = mode_spec_i;
		s_next.sw[sdsm_pkg::SW_ABS_BIT]                       = abs_valid_i;
		s_next.sw[sdsm_pkg::SW_BUSY_BIT]                      = busy_i;

		// Per-mode function enables
		s_next.common = mode_supported(s_reg.mode_disp);
		unique case (s_reg.mode_disp)
			sdsm_pkg::profile_position_mode, sdsm_pkg::cyclic_position_mode: begin
				s_next.vel_ff   = 1'b1;
				s_next.pos_filt = 1'b1;
				s_next.trq_ff   = 1'b1;
				s_next.dob      = 1'b1;
			end
			sdsm_pkg::profile_velocity_mode, sdsm_pkg::cyclic_velocity_mode: begin
				s_next.vel_ff   = 1'b0;
				s_next.pos_filt = 1'b0;
				s_next.trq_ff   = 1'b1;
				s_next.dob      = 1'b1;
			end
			sdsm_pkg::homing_mode: begin
				s_next.vel_ff   = homing_pos_ctrl_i;
				s_next.pos_filt = homing_pos_ctrl_i;
				s_next.trq_ff   = 1'b1;
				s_next.dob      = 1'b1;
			end
			default: begin
				// Torque modes and no mode yet
				s_next.vel_ff   = 1'b0;
				s_next.pos_filt = 1'b0;
				s_next.trq_ff   = 1'b0;
				s_next.dob      = 1'b0;
			end
		endcase
	end

	// Whole state resets to zero, which is also the not-ready code
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign emcy.alarm_evt  = s_reg.alarm_evt;
	assign emcy.alarm_code = s_reg.alarm_code;
	assign emcy.err_reg    = sdsm_pkg::ERR_REG_GENERIC;

	sdsm_emcy_fmt u_fmt (
		.clock_i    (clock_i),
		.sys_rst_i  (sys_rst_i),
		.link_up_i  (link_up_i),
		.emcy_ack_i (emcy_ack_i),
		.emcy       (emcy.fmt)
	);

	assign cycle_tick_o    = s_reg.tick;
	assign drive_state_o   = s_reg.state;
	assign obj_rdata_o     = s_reg.rdata;
	assign obj_ack_o       = s_reg.ack;
	assign obj_err_o       = s_reg.err;
	assign emcy_valid_o    = emcy.msg_valid;
	assign emcy_data_o     = emcy.msg;
	assign vel_ff_en_o     = s_reg.vel_ff;
	assign pos_filter_en_o = s_reg.pos_filt;
	assign torque_ff_en_o  = s_reg.trq_ff;
	assign observer_en_o   = s_reg.dob;
	assign common_en_o     = s_reg.common;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	localparam int ReactMax = REACT_CYCLES + 1;

	sequence react_entered;
		alarm_i && alarm_free;
	endsequence
	sequence fault_reached;
		s_reg.state == sdsm_pkg::ST_FAULT;
	endsequence

	chk_dc_tick_cause: assert property (sync_mode_i == sdsm_pkg::SYNC_DC |=> s_reg.tick == $past(sync_edge))
		else $error("sync tick not tied to sync event");
	chk_free_wrap: assert property (sync_mode_i == sdsm_pkg::SYNC_FREE_RUN && !(sm_corr_en_i && sm_edge)
		&& s_reg.cyc_cnt == CYC_LAST |=> s_reg.tick && s_reg.cyc_cnt == 16'h0000)
		else $error("free-running cycle did not wrap");
	chk_sm_realign: assert property (sync_mode_i == sdsm_pkg::SYNC_FREE_RUN && sm_corr_en_i && sm_edge
		|=> s_reg.cyc_cnt == 16'h0000 && !s_reg.tick)
		else $error("sync manager correction missing");
	chk_alarm_fault: assert property (react_entered |=> s_reg.state == sdsm_pkg::ST_FAULT_REACT ##[1:ReactMax] fault_reached)
		else $error("fault reaction did not reach fault");
	chk_shutdown_cmd: assert property (s_reg.state == sdsm_pkg::ST_SW_DISABLED && cmd_shutdown && !alarm_i
		|=> s_reg.state == sdsm_pkg::ST_READY)
		else $error("shutdown did not reach ready");
	chk_disable_volt: assert property (alarm_free && s_reg.state != sdsm_pkg::ST_SW_DISABLED && cmd_dis_volt
		&& !alarm_i |=> s_reg.state == sdsm_pkg::ST_SW_DISABLED)
		else $error("disable voltage ignored");
	chk_reset_level: assert property (s_reg.state == sdsm_pkg::ST_FAULT && s_reg.cw7_prev
		|=> s_reg.state == sdsm_pkg::ST_FAULT)
		else $error("held fault reset level left fault");
	chk_idle_cmd: assert property (s_reg.state == sdsm_pkg::ST_SW_DISABLED && !cmd_shutdown && !alarm_i
		|=> $stable(s_reg.state))
		else $error("invalid command changed state");
	chk_state_code: assert property (1'b1 |=> {s_reg.sw[6:5], s_reg.sw[3:0]} == state_code($past(s_reg.state)))
		else $error("state word code mismatch");
	chk_mode_disp: assert property (obj_wr_i && obj_index_i == sdsm_pkg::IDX_MODE_SELECT
		&& mode_supported(obj_wdata_i[7:0]) |=> ##1 s_reg.mode_disp == $past(obj_wdata_i[7:0], 2))
		else $error("mode display not updated");
	chk_torque_funcs: assert property (s_reg.mode_disp == sdsm_pkg::cyclic_torque_mode
		|=> !s_reg.trq_ff && !s_reg.dob && !s_reg.vel_ff && s_reg.common)
		else $error("torque mode function enables wrong");
endmodule : sdsm_drive

// File: sdsm_emcy_fmt.sv
// Emergency message formatter holding one 8-byte mailbox message
`timescale 1ns/10ps
module sdsm_emcy_fmt (
	input  wire logic   clock_i,
	input  wire logic   sys_rst_i,
	input  wire logic   link_up_i,
	input  wire logic   emcy_ack_i,
	sdsm_emcy_if.fmt    emcy
);
	typedef struct packed {
		logic        valid;
		logic [63:0] msg;
	} sdsm_fmt_s;

	sdsm_fmt_s s_reg;
	sdsm_fmt_s s_next;

	localparam logic [15:0] EMCY_CODE_W = sdsm_pkg::EMCY_CODE;

	always_comb begin
		s_next = s_reg;
		if (emcy_ack_i) begin
			s_next.valid = 1'b0;
		end
		// New alarm wins over the ack; lost silently when the link is down
		if (emcy.alarm_evt && link_up_i) begin
			s_next.valid = 1'b1;
			s_next.msg   = {16'h0000, emcy.alarm_code, 8'h00, emcy.err_reg, EMCY_CODE_W};
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign emcy.msg_valid = s_reg.valid;
	assign emcy.msg       = s_reg.msg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	chk_emcy_layout: assert property (emcy.alarm_evt && link_up_i |=>
		s_reg.valid && s_reg.msg[15:0] == EMCY_CODE_W && s_reg.msg[31:24] == 8'h00
		&& s_reg.msg[47:32] == $past(emcy.alarm_code) && s_reg.msg[63:48] == 16'h0000)
		else $error("emergency message layout wrong");
	chk_emcy_hold: assert property (s_reg.valid && !emcy_ack_i && !emcy.alarm_evt |=>
		s_reg.valid && $stable(s_reg.msg))
		else $error("emergency message dropped before ack");
endmodule : sdsm_emcy_fmt

// File: sdsm_emcy_if.sv
// Alarm event and emergency message carrier between drive core and formatter
`timescale 1ns/10ps
interface sdsm_emcy_if;
	logic        alarm_evt;
	logic [15:0] alarm_code;
	logic [7:0]  err_reg;
	logic        msg_valid;
	logic [63:0] msg;

	modport fmt (input alarm_evt, input alarm_code, input err_reg, output msg_valid, output msg);
	modport core (output alarm_evt, output alarm_code, output err_reg, input msg_valid, input msg);
endinterface : sdsm_emcy_if

// File: sdsm_master_model.sv
// Master-side model: sync event pin and emergency mailbox acknowledge
`timescale 1ns/10ps
module sdsm_master_model (
	input  wire logic       clock_i,
	input  wire logic       sync_req_i,
	input  wire logic       emcy_valid_i,
	input  wire logic [3:0] ack_dly_i,
	output logic            sync_event_o,
	output logic            emcy_ack_o
);
	int sc = 0;
	int ac = 0;
	initial begin
		sync_event_o = 1'b0;
		emcy_ack_o = 1'b0;
	end
	// Pin idles low between events; two cycles high so the synchronizer sees it
	always @(posedge clock_i) begin
		sync_event_o <= #1 sync_req_i && (sc < 2);
		sc <= (!sync_req_i || sc == 9) ? 0 : sc + 1;
		// Slow or prompt acknowledge, one cycle wide
		emcy_ack_o <= #1 (emcy_valid_i === 1'b1) && (ac == ack_dly_i) && !emcy_ack_o;
		ac <= (emcy_valid_i === 1'b1 && ac < 15) ? ac + 1 : 0;
	end
endmodule : sdsm_master_model

// File: sdsm_pkg.sv
// Constants, encodings and timing for the servo drive state machine
package sdsm_pkg;

	// Object dictionary indices
	localparam logic [15:0] IDX_CMD_WORD     = 16'h6040;
	localparam logic [15:0] IDX_STATE_WORD   = 16'h6041;
	localparam logic [15:0] IDX_MODE_SELECT  = 16'h6060;
	localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;
	localparam logic [15:0] IDX_MODE_SET     = 16'h6502;

	// Values after reset
	localparam logic [15:0] CMD_WORD_RESET   = 16'h0000;
	localparam logic [7:0]  MODE_RESET       = 8'h00;

	// Synchronization mode input
	localparam logic SYNC_FREE_RUN = 1'b0;
	localparam logic SYNC_DC       = 1'b1;

	// Drive states; not ready must stay the all-zero code
	typedef enum logic [2:0] {
		ST_NOT_READY   = 3'b000,
		ST_SW_DISABLED = 3'b001,
		ST_READY       = 3'b010,
		ST_SWITCHED_ON = 3'b011,
		ST_OP_ENABLED  = 3'b100,
		ST_QUICK_STOP  = 3'b101,
		ST_FAULT_REACT = 3'b110,
		ST_FAULT       = 3'b111
	} sdsm_state_e;

	// State word codes, bits {6,5,3,2,1,0}
	localparam logic [5:0] CODE_NOT_READY   = 6'h00;
	localparam logic [5:0] CODE_SW_DISABLED = 6'h30;
	localparam logic [5:0] CODE_READY       = 6'h11;
	localparam logic [5:0] CODE_SWITCHED_ON = 6'h13;
	localparam logic [5:0] CODE_OP_ENABLED  = 6'h17;
	localparam logic [5:0] CODE_QUICK_STOP  = 6'h07;
	localparam logic [5:0] CODE_FAULT_REACT = 6'h1F;
	localparam logic [5:0] CODE_FAULT       = 6'h18;

	// Command word bit positions
	localparam int CW_FAULT_RESET_BIT = 7;

	// State word bit positions
	localparam int SW_VOLTAGE_BIT  = 4;
	localparam int SW_WARNING_BIT  = 7;
	localparam int SW_REMOTE_BIT   = 9;
	localparam int SW_TARGET_BIT   = 10;
	localparam int SW_LIMIT_BIT    = 11;
	localparam int SW_MODE_LO_BIT  = 12;
	localparam int SW_ABS_BIT      = 14;
	localparam int SW_BUSY_BIT     = 15;

	// Operation mode codes
	localparam logic [7:0] profile_position_mode = 8'h01;
	localparam logic [7:0] profile_velocity_mode = 8'h03;
	localparam logic [7:0] profile_torque_mode   = 8'h04;
	localparam logic [7:0] homing_mode           = 8'h06;
	localparam logic [7:0] cyclic_position_mode  = 8'h08;
	localparam logic [7:0] cyclic_velocity_mode  = 8'h09;
	localparam logic [7:0] cyclic_torque_mode    = 8'h0A;
	localparam logic [31:0] SUPPORTED_MODES      = 32'h0000_03AD;

	// Emergency message fields
	localparam logic [15:0] EMCY_CODE        = 16'hFF00;
	localparam logic [7:0]  ERR_REG_GENERIC  = 8'h01;

	// Timing
	localparam int CLOCK_PERIOD_NS    = 100;
	localparam int FREE_CYCLE_NS      = 1000;
	localparam int FAULT_REACT_NS     = 1000;
	localparam int FREE_CYCLE_CYCLES  = FREE_CYCLE_NS / CLOCK_PERIOD_NS;
	localparam int FAULT_REACT_CYCLES = (FAULT_REACT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage : sdsm_pkg

// File: testbench.sv
// Self-checking bench for the servo drive state machine
`timescale 1ns/10ps
module testbench;
	logic        clock_i = 0, sys_rst_i = 1, sync_mode_i = 0, obj_wr_i = 0, obj_rd_i = 0, sync_req = 0;
	logic        alarm_i = 0, link_up_i = 1, homing_pos_ctrl_i = 0;
	logic        cycle_tick_o, obj_ack_o, obj_err_o, emcy_valid_o, emcy_ack_i, sync_event_i;
	logic [15:0] obj_index_i = 16'h0000, alarm_code_i = 16'hA5C3;
	logic [31:0] obj_wdata_i = 32'h0, obj_rdata_o;
	logic [7:0]  sv = 8'h00;
	logic [3:0]  ack_dly = 4'h5;
	logic [63:0] emcy_data_o;
	logic [4:0]  en;
	logic [2:0]  drive_state_o;
	logic        sm_corr = 0, sm_evt = 0;
	logic [15:0] cmd_t [19] = '{16'h0006, 16'h0007, 16'h000F, 16'h0007, 16'h000F, 16'h0002, 16'h000F,
		16'h000D, 16'h000F, 16'h0006, 16'h000F, 16'h0006, 16'h000F, 16'h0002, 16'h0000, 16'h0006,
		16'h0002, 16'h0006, 16'h000F};
	logic [2:0]  st_t [19] = '{3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h5, 3'h4, 3'h1, 3'h1, 3'h2, 3'h4, 3'h2, 3'h4,
		3'h5, 3'h1, 3'h2, 3'h1, 3'h2, 3'h4};
	logic [15:0] sw_t [19] = '{16'h0221, 16'h0223, 16'h0227, 16'h0223, 16'h0227, 16'h0207, 16'h0227,
		16'h0260, 16'h0260, 16'h0221, 16'h0227, 16'h0221, 16'h0227, 16'h0207, 16'h0260, 16'h0221,
		16'h0260, 16'h0221, 16'h0227};
	logic [7:0]  md_t [7] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
	logic [4:0]  en_t [7] = '{5'h1F, 5'h07, 5'h01, 5'h07, 5'h1F, 5'h07, 5'h01};
	int          n_errors = 0, total_checks = 0, k, c;

	// Short counts keep the run brief
	sdsm_drive #(.FREE_CYCLES(4), .REACT_CYCLES(3)) sdsm_drive_i (.clock_i, .sys_rst_i, .sync_mode_i,
		.sm_corr_en_i(sm_corr), .sync_event_i, .sm_event_i(sm_evt), .obj_index_i, .obj_wr_i, .obj_rd_i,
		.obj_wdata_i, .alarm_i, .alarm_code_i, .link_up_i, .emcy_ack_i, .voltage_on_i(sv[0]),
		.warning_i(sv[1]), .target_reached_i(sv[2]), .limit_active_i(sv[3]), .mode_spec_i(sv[5:4]),
		.abs_valid_i(sv[6]), .busy_i(sv[7]), .homing_pos_ctrl_i, .cycle_tick_o, .drive_state_o,
		.obj_rdata_o, .obj_ack_o, .obj_err_o, .emcy_valid_o, .emcy_data_o, .vel_ff_en_o(en[4]),
		.pos_filter_en_o(en[3]), .torque_ff_en_o(en[2]), .observer_en_o(en[1]), .common_en_o(en[0]));
	sdsm_master_model sdsm_master_model_i (.clock_i, .sync_req_i(sync_req), .emcy_valid_i(emcy_valid_o),
		.ack_dly_i(ack_dly), .sync_event_o(sync_event_i), .emcy_ack_o(emcy_ack_i));

	initial forever #50 clock_i = ~clock_i;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cyc
	// One strobe cycle, then answer checked in the cycle it stands
	task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		@(posedge clock_i) #1;
		obj_wr_i = wr;
		obj_rd_i = !wr;
		obj_index_i = idx;
		obj_wdata_i = d;
		cyc(1);
		obj_wr_i = 1'b0;
		obj_rd_i = 1'b0;
		chk(obj_ack_o, 1, "ack");
	endtask : obj
	task automatic ticks(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			cyc(1);
			if (cycle_tick_o === 1'b1) cnt++;
		end
	endtask : ticks
	task end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim

	initial begin
		#5_000_000;
		n_errors++;
		$display("[FAIL] run expected done seen hang");
		end_sim();
	end

	initial begin
		cyc(16);
		chk(drive_state_o, 0, "reset state");
		chk(emcy_valid_o, 0, "reset emcy");
		sys_rst_i = 1'b0;
		cyc(1);
		chk(drive_state_o, 1, "init state");
		for (k = 0; k < 19; k++) begin
			obj(1'b1, 16'h6040, {16'h0, cmd_t[k]});
			cyc(2);
			chk(drive_state_o, st_t[k], "state");
			obj(1'b0, 16'h6041, 32'h0);
			chk(obj_rdata_o, sw_t[k], "state word");
		end
		for (k = 0; k < 7; k++) begin
			obj(1'b1, 16'h6060, {24'h0, md_t[k]});
			cyc(2);
			chk(en, en_t[k], "enables");
			obj(1'b0, 16'h6061, 32'h0);
			chk(obj_rdata_o, md_t[k], "mode display");
		end
		homing_pos_ctrl_i = 1'b1;
		obj(1'b1, 16'h6060, 32'h06);
		cyc(2);
		chk(en, 5'h1F, "homing enables");
		obj(1'b1, 16'h6060, 32'h05);
		cyc(2);
		obj(1'b0, 16'h6061, 32'h0);
		chk(obj_rdata_o, 32'h06, "kept mode");
		obj(1'b0, 16'h6502, 32'h0);
		chk(obj_rdata_o, 32'h0000_03AD, "mode set");
		obj(1'b1, 16'h6502, 32'hFFFF);
		chk(obj_err_o, 1, "ro write");
		obj(1'b0, 16'h1234, 32'h0);
		chk({obj_err_o, obj_rdata_o}, 33'h1_0000_0000, "unknown read");
		sv = 8'hFF;
		cyc(2);
		obj(1'b0, 16'h6041, 32'h0);
		chk(obj_rdata_o, 32'hFEB7, "status bits");
		sv = 8'h00;
		alarm_i = 1'b1;
		for (k = 0; k < 10 && emcy_valid_o !== 1'b1; k++) cyc(1);
		chk(emcy_valid_o, 1, "emcy valid");
		chk(emcy_data_o, 64'h0000_A5C3_0001_FF00, "emcy msg");
		cyc(6);
		chk(drive_state_o, 7, "fault");
		obj(1'b1, 16'h6040, 32'h0080);
		cyc(2);
		chk(drive_state_o, 7, "reset refused");
		chk(emcy_valid_o, 0, "emcy acked");
		alarm_i = 1'b0;
		obj(1'b1, 16'h6040, 32'h0000);
		obj(1'b1, 16'h6040, 32'h0080);
		cyc(2);
		chk(drive_state_o, 1, "fault reset");
		ticks(40, c);
		chk(c, 10, "free ticks");
		sync_mode_i = 1'b1;
		ticks(20, c);
		chk(c, 0, "dc idle ticks");
		sync_req = 1'b1;
		ticks(40, c);
		sync_req = 1'b0;
		chk(c, 4, "dc ticks");
		// Sync manager edges every third cycle keep the counter from wrapping
		sync_mode_i = 1'b0;
		sm_corr = 1'b1;
		c = 0;
		for (k = 0; k < 12; k++) begin
			sm_evt = (k % 3 == 0);
			cyc(1);
			if (k > 5 && cycle_tick_o === 1'b1) c++;
		end
		chk(c, 0, "sm realign");
		sm_corr = 1'b0;
		link_up_i = 1'b0;
		alarm_i = 1'b1;
		cyc(8);
		chk(emcy_valid_o, 0, "link down drop");
		end_sim();
	end
endmodule : testbench
